//--- dv/pdp_pixel_path_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "pdp_consts.vh"
module pdp_pixel_path_bench;
    logic       clk, arst_n, pix_valid, pix_ready, sync_n, blank_n, host_wr_n, host_rd_n, host_d_oe;
    logic       video_ready, video_valid, video_sync_source_on, video_pedestal_on;
    logic [7:0] red_pixel_in, green_pixel_in, blue_pixel_in, host_d_in, host_d_out;
    logic [7:0] analog_color_red, analog_color_green, analog_color_blue;
    logic [3:0] overlay_select, general_output_bits;
    logic [2:0] host_rs;
    logic [1:0] mode_select_pins;
    int         fails = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    pdp_pixel_path #(.FIFO_DEPTH(16), .FIFO_AW(4)) pdp_pixel_path_inst (.clk, .arst_n, .pix_valid,
        .pix_ready, .red_pixel_in, .green_pixel_in, .blue_pixel_in, .mode_select_pins, .overlay_select,
        .sync_n, .blank_n, .host_rs, .host_wr_n, .host_rd_n, .host_d_in, .host_d_out, .host_d_oe,
        .general_output_bits, .video_ready, .video_valid, .analog_color_red, .analog_color_green,
        .analog_color_blue, .video_sync_source_on, .video_pedestal_on);
    pdp_src_model pdp_src_model_inst (.clk, .pix_ready, .pix_valid, .red_pixel_in, .green_pixel_in,
        .blue_pixel_in, .mode_select_pins, .overlay_select, .sync_n, .blank_n);
    // clock, and a ceiling of cycles so a hang still ends the run
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            $display("Error timeout expected finish seen hang");
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] v);
        samples_checked++;
        if (v !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, v);
        end
    endtask
    // host cycles: write strobe held over one rising edge, read strobe over two, then high for a cycle
    task automatic hw(input logic [2:0] rs, input logic [7:0] d);
        @(negedge clk);
        {host_rs, host_d_in, host_wr_n} = {rs, d, 1'b0};
        @(negedge clk);
        host_wr_n = 1'b1;
        @(negedge clk);
    endtask
    task automatic hr(input logic [2:0] rs, output logic [7:0] d);
        @(negedge clk);
        {host_rs, host_rd_n} = {rs, 1'b0};
        repeat (2) @(negedge clk);
        d = host_d_out;
        chk("oe", 8'h01, {7'h00, host_d_oe});
        host_rd_n = 1'b1;
        @(negedge clk);
    endtask
    // wait for the next shown word and judge it while it stands
    task automatic out(input logic [7:0] er, eg, eb, input logic [1:0] sp);
        for (int i = 0; i < 20 && video_valid !== 1'b1; i++)
            @(negedge clk);
        chk("red", er, analog_color_red);
        chk("green", eg, analog_color_green);
        chk("blue", eb, analog_color_blue);
        chk("sync_ped", {6'h00, sp}, {6'h00, video_sync_source_on, video_pedestal_on});
        @(negedge clk);
    endtask
    task automatic pix(input logic [7:0] r, g, input logic [1:0] m, input logic [3:0] o, input logic s, bl,
                       input logic [7:0] er, eg, eb, input logic [1:0] sp);
        logic ok;
        pdp_src_model_inst.push(r, g, 8'hFF, m, o, s, bl, ok);
        chk("taken", 8'h01, {7'h00, ok});
        out(er, eg, eb, sp);
    endtask
    task automatic t_cmd;
        logic [7:0] d;
        hw(`PDP_RS_CMD, 8'hC5);
        chk("gpo", 8'h05, {4'h0, general_output_bits});
        hr(`PDP_RS_CMD, d);
        chk("cmd", 8'hC5, d);
        hw(`PDP_RS_MASK, 8'h5A);
        hr(`PDP_RS_MASK, d);
        chk("mask", 8'h5A, d);
        $display("t_cmd done");
    endtask
    task automatic t_byp;
        hw(`PDP_RS_CMD, 8'hF0);
        hw(`PDP_RS_MASK, 8'h00);
        pix(8'hB5, 8'h6C, 2'h3, 4'h0, 1'b0, 1'b1, 8'h68, 8'h58, 8'h60, 2'b01);
        $display("t_byp done");
    endtask
    task automatic t_pal;
        logic [7:0] v;
        v = 8'h11;
        hw(`PDP_RS_PAL_WADDR, 8'h05);
        repeat (3) begin
            hw(`PDP_RS_PAL_DATA, v);
            v += 8'h11;
        end
        hw(`PDP_RS_PAL_WADDR, 8'h01);
        repeat (3) begin
            hw(`PDP_RS_PAL_DATA, v);
            v += 8'h11;
        end
        hw(`PDP_RS_MASK, 8'hFF);
        hw(`PDP_RS_CMD, 8'hD0);
        pix(8'h94, 8'hA5, 2'h2, 4'h0, 1'b1, 1'b1, 8'h11, 8'h22, 8'h33, 2'b10);
        hw(`PDP_RS_MASK, 8'h01);
        pix(8'h94, 8'hA5, 2'h2, 4'h0, 1'b1, 1'b1, 8'h44, 8'h55, 8'h66, 2'b10);
        $display("t_pal done");
    endtask
    task automatic t_ovl;
        hw(`PDP_RS_OVL_WADDR, 8'h03);
        hw(`PDP_RS_OVL_DATA, 8'h77);
        hw(`PDP_RS_OVL_DATA, 8'h88);
        hw(`PDP_RS_OVL_DATA, 8'h99);
        pix(8'h94, 8'hA5, 2'h1, 4'h3, 1'b1, 1'b1, 8'h77, 8'h88, 8'h99, 2'b10);
        hw(`PDP_RS_CMD, 8'hF0);
        pix(8'h94, 8'hA5, 2'h3, 4'h3, 1'b1, 1'b0, 8'h00, 8'h00, 8'h00, 2'b10);
        $display("t_ovl done");
    endtask
    // converter stalls until the buffer refuses, then drains in order
    task automatic t_fill;
        logic       ok;
        logic [7:0] n;
        {ok, n} = 9'h100;
        @(negedge clk);
        video_ready = 1'b0;
        while (ok && n < 8'd30) begin
            pdp_src_model_inst.push({n[5:0], 2'h0}, 8'h00, 8'hFF, 2'h3, 4'h0, 1'b1, 1'b1, ok);
            n = n + {7'h00, ok};
        end
        chk("refused", 8'h01, {7'h00, n >= 8'd16});
        video_ready = 1'b1;
        for (int i = 0; i < n; i++)
            out({i[4:0], 3'h0}, 8'h00, 8'h00, 2'b11);
        chk("empty", 8'h00, {7'h00, video_valid});
        $display("t_fill done");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        {host_rs, host_wr_n, host_rd_n, host_d_in, video_ready} = {3'h0, 2'b11, 8'h00, 1'b1};
        repeat (2) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_cmd();
        t_byp();
        t_pal();
        t_ovl();
        t_fill();
        end_sim();
    end
endmodule
`default_nettype wire

//--- dv/pdp_pixel_path_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "pdp_consts.vh"
// -----
// pixel path checker
// -----
module pdp_pixel_path_sva #(
    parameter FIFO_DEPTH = 16
) (
    input wire       clk,
    input wire       arst_n,
    input wire       pix_valid,
    input wire       pix_ready,
    input wire       sync_n,
    input wire       blank_n,
    input wire [2:0] host_rs,
    input wire       host_wr_n,
    input wire       host_rd_n,
    input wire [7:0] host_d_in,
    input wire [7:0] host_d_out,
    input wire [3:0] general_output_bits,
    input wire       video_ready,
    input wire       video_valid,
    input wire [7:0] analog_color_red,
    input wire [7:0] analog_color_green,
    input wire [7:0] analog_color_blue,
    input wire       video_sync_source_on,
    input wire       video_pedestal_on
);
    // words in flight; strobe history, since a cycle is taken on the falling strobe only
    logic [5:0] infl_reg;
    logic       wr_q_reg;
    logic       rd_q_reg;
    wire        cmd_wr = host_rs == `PDP_RS_CMD && !host_wr_n && wr_q_reg;
    wire        rd_take = !host_rd_n && rd_q_reg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            infl_reg <= 6'h00;
            wr_q_reg <= 1'b1;
            rd_q_reg <= 1'b1;
        end else begin
            infl_reg <= infl_reg + {5'h00, pix_valid && pix_ready} - {5'h00, video_valid && video_ready};
            wr_q_reg <= host_wr_n;
            rd_q_reg <= host_rd_n;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_gpo_load: assert property (cmd_wr |=> general_output_bits == $past(host_d_in[3:0]))
        else $error("gpo missed command write");
    a_gpo_hold: assert property (!$stable(general_output_bits) |-> $past(cmd_wr))
        else $error("gpo changed without write");
    a_read_hold: assert property (!$stable(host_d_out) |-> $past(rd_take) || $past(rd_take, 2))
        else $error("read data changed without read");
    a_lat_fixed: assert property (pix_valid && pix_ready && infl_reg == 6'h00 ##1 video_ready [*3] |=>
        video_valid && video_sync_source_on == $past(sync_n, 4)) else $error("pixel latency off");
    a_blank_zero: assert property (pix_valid && pix_ready && infl_reg == 6'h00 ##1 video_ready [*3] |=>
        $past(blank_n, 4) || {analog_color_red, analog_color_green, analog_color_blue, video_pedestal_on} == 25'h0)
        else $error("blanked pixel not dark");
    a_stall_hold: assert property (video_valid && !video_ready |=> video_valid && $stable(analog_color_red)
        && $stable(analog_color_green) && $stable(analog_color_blue)) else $error("output moved while stalled");
    a_full_refuse: assert property (!pix_ready |-> infl_reg >= FIFO_DEPTH)
        else $error("refused before buffer full");
    a_valid_item: assert property (video_valid |-> infl_reg != 6'h00)
        else $error("valid with nothing in flight");
endmodule
bind pdp_pixel_path pdp_pixel_path_sva #(.FIFO_DEPTH(FIFO_DEPTH)) pdp_pixel_path_sva_inst (.clk, .arst_n,
    .pix_valid, .pix_ready, .sync_n, .blank_n, .host_rs, .host_wr_n, .host_rd_n, .host_d_in, .host_d_out,
    .general_output_bits, .video_ready, .video_valid, .analog_color_red, .analog_color_green,
    .analog_color_blue, .video_sync_source_on, .video_pedestal_on);
`default_nettype wire

//--- dv/pdp_src_model.sv
`timescale 1ns/10ps
`default_nettype none
// -----
// graphics controller: pixel source
// -----
module pdp_src_model (
    input  wire            clk,
    input  wire            pix_ready,
    output var logic       pix_valid,
    output var logic [7:0] red_pixel_in,
    output var logic [7:0] green_pixel_in,
    output var logic [7:0] blue_pixel_in,
    output var logic [1:0] mode_select_pins,
    output var logic [3:0] overlay_select,
    output var logic       sync_n,
    output var logic       blank_n
);
    // idle: nothing offered, sync and blank inactive
    initial begin
        {pix_valid, red_pixel_in, green_pixel_in, blue_pixel_in} = 25'h0;
        {mode_select_pins, overlay_select, sync_n, blank_n} = 8'h03;
    end
    // offer one pixel and hold it until taken, giving up after 8 tries
    task automatic push(input logic [7:0] r, g, b, input logic [1:0] m, input logic [3:0] o,
                        input logic s, bl, output logic ok);
        @(negedge clk);
        {red_pixel_in, green_pixel_in, blue_pixel_in} = {r, g, b};
        {mode_select_pins, overlay_select, sync_n, blank_n} = {m, o, s, bl};
        pix_valid = 1'b1;
        ok = 1'b0;
        for (int i = 0; i < 8 && !ok; i++) begin
            ok = pix_ready;
            @(negedge clk);
        end
        // released color lines show the inverse so a stale pixel cannot pass
        pix_valid = 1'b0;
        {red_pixel_in, green_pixel_in, blue_pixel_in} = ~{r, g, b};
    endtask
endmodule
`default_nettype wire

//--- hdl/pdp_consts.vh
`ifndef PDP_CONSTS_VH
`define PDP_CONSTS_VH

// ----------------------------------------
// register select codes
// ----------------------------------------
`define PDP_RS_PAL_WADDR 3'h0
`define PDP_RS_PAL_DATA  3'h1
`define PDP_RS_MASK      3'h2
`define PDP_RS_PAL_RADDR 3'h3
`define PDP_RS_OVL_WADDR 3'h4
`define PDP_RS_OVL_DATA  3'h5
`define PDP_RS_CMD       3'h6
`define PDP_RS_OVL_RADDR 3'h7

// ----------------------------------------
// command register fields and reset values
// ----------------------------------------
`define PDP_CMD_MODE_HI  7
`define PDP_CMD_MODE_LO  6
`define PDP_CMD_PEDESTAL 5
`define PDP_CMD_WIDTH    4
`define PDP_CMD_GPO_HI   3
`define PDP_CMD_RESET    8'h00
`define PDP_MASK_RESET   8'h00

// ----------------------------------------
// mode select pin codes and command mode codes
// ----------------------------------------
`define PDP_SEL_TRUE     2'h0
`define PDP_SEL_TRUE_BYP 2'h1
`define PDP_SEL_PSEUDO   2'h2
`define PDP_SEL_8_BYP    2'h3
`define PDP_CM_RED       2'h0
`define PDP_CM_GREEN     2'h1
`define PDP_CM_15BIT     2'h3

// ----------------------------------------
// pixel source kinds inside the pipeline
// ----------------------------------------
`define PDP_KIND_ZERO    2'h0
`define PDP_KIND_PAL     2'h1
`define PDP_KIND_BYP     2'h2
`define PDP_KIND_OVL     2'h3

// color triplet step: red, green, blue
`define PDP_STEP_BLUE    2'h2

`endif

//--- hdl/pdp_fifo.v
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// synchronous fifo, valid/ready both sides
// ----------------------------------------
module pdp_fifo #(
    parameter WIDTH  = 26,
    parameter DEPTH  = 16,
    parameter ADDR_W = 4
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0]  mem [0:DEPTH-1];
    reg [ADDR_W-1:0] wr_ptr_reg;
    reg [ADDR_W-1:0] rd_ptr_reg;
    reg [ADDR_W:0]   count_reg;
    wire             push;
    wire             pop;

    // full and empty straight from the count
    assign in_ready  = (count_reg != DEPTH[ADDR_W:0]);
    assign out_valid = (count_reg != {(ADDR_W+1){1'b0}});
    assign out_data  = mem[rd_ptr_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // storage carries no reset, only pointers and count do
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // pointer wrap assumes depth is a power of two
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= {ADDR_W{1'b0}};
            rd_ptr_reg <= {ADDR_W{1'b0}};
            count_reg  <= {(ADDR_W+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop & ~push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- hdl/pdp_pixel_path.v
`timescale 1ns/10ps
`default_nettype none
`include "pdp_consts.vh"
module pdp_pixel_path #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW    = 4
) (
    input  wire       clk,
    input  wire       arst_n,
    input  wire       pix_valid,
    output wire       pix_ready,
    input  wire [7:0] red_pixel_in,
    input  wire [7:0] green_pixel_in,
    input  wire [7:0] blue_pixel_in,
    input  wire [1:0] mode_select_pins,
    input  wire [3:0] overlay_select,
    input  wire       sync_n,
    input  wire       blank_n,
    input  wire [2:0] host_rs,
    input  wire       host_wr_n,
    input  wire       host_rd_n,
    input  wire [7:0] host_d_in,
    output wire [7:0] host_d_out,
    output wire       host_d_oe,
    output wire [3:0] general_output_bits,
    input  wire       video_ready,
    output wire       video_valid,
    output wire [7:0] analog_color_red,
    output wire [7:0] analog_color_green,
    output wire [7:0] analog_color_blue,
    output wire       video_sync_source_on,
    output wire       video_pedestal_on
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    reg rst_meta_reg;
    reg rst_n_reg;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // ----------------------------------------
    // host side registers
    // ----------------------------------------
    reg  [7:0] pal_red [0:255], pal_green [0:255], pal_blue [0:255];
    reg  [7:0] ovl_red [0:15], ovl_green [0:15], ovl_blue [0:15];
    reg  [7:0] command_control_reg, mask_red_reg, mask_green_reg, mask_blue_reg;
    reg  [7:0] addr_reg, hold_red_reg, hold_green_reg, d_out_reg, rd_value, rd_color;
    reg  [1:0] step_reg;
    reg        wr_n_q_reg, rd_n_q_reg;
    wire       wr_fall, rd_fall, wide_colors, data_wr, data_rd, last_step;
    wire [7:0] color_in;

    assign wr_fall     = ~host_wr_n & wr_n_q_reg;
    assign rd_fall     = ~host_rd_n & rd_n_q_reg;
    assign wide_colors = command_control_reg[`PDP_CMD_WIDTH];
    // narrow mode takes low six bits as the top of the color
    assign color_in    = wide_colors ? host_d_in : {host_d_in[5:0], 2'b00};
    assign data_wr     = wr_fall & (host_rs == `PDP_RS_PAL_DATA || host_rs == `PDP_RS_OVL_DATA);
    assign data_rd     = rd_fall & (host_rs == `PDP_RS_PAL_DATA || host_rs == `PDP_RS_OVL_DATA);
    assign last_step   = (step_reg == `PDP_STEP_BLUE);
    assign general_output_bits = command_control_reg[`PDP_CMD_GPO_HI:0];
    assign host_d_out  = d_out_reg;
    assign host_d_oe   = ~host_rd_n;

    // strobe edges, address and triplet step
    always @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            {wr_n_q_reg, rd_n_q_reg} <= 2'b11;
            {addr_reg, step_reg, hold_red_reg, hold_green_reg, d_out_reg} <= 34'h000000000;
            command_control_reg <= `PDP_CMD_RESET;
            {mask_red_reg, mask_green_reg, mask_blue_reg} <= {3{`PDP_MASK_RESET}};
        end else begin
            wr_n_q_reg <= host_wr_n;
            rd_n_q_reg <= host_rd_n;
            if (rd_fall) begin
                d_out_reg <= rd_value;
            end
            if (wr_fall) begin
                case (host_rs)
                    `PDP_RS_PAL_WADDR, `PDP_RS_PAL_RADDR,
                    `PDP_RS_OVL_WADDR, `PDP_RS_OVL_RADDR: begin
                        addr_reg <= host_d_in;
                        step_reg <= 2'h0;
                    end
                    `PDP_RS_MASK: begin
                        mask_red_reg   <= host_d_in;
                        mask_green_reg <= host_d_in;
                        mask_blue_reg  <= host_d_in;
                    end
                    `PDP_RS_CMD: begin
                        command_control_reg <= host_d_in;
                    end
                    default: begin
                        if (step_reg == 2'h0) begin
                            hold_red_reg <= color_in;
                        end
                        if (step_reg == 2'h1) begin
                            hold_green_reg <= color_in;
                        end
                    end
                endcase
            end
            // triplet step advances on each color access
            if (data_wr | data_rd) begin
                if (last_step) begin
                    step_reg <= 2'h0;
                    addr_reg <= addr_reg + 8'h01;
                end else begin
                    step_reg <= step_reg + 2'h1;
                end
            end
        end
    end

    // color tables written once the blue byte lands
    always @(posedge clk) begin
        if (data_wr && last_step) begin
            if (host_rs == `PDP_RS_PAL_DATA) begin
                pal_red[addr_reg]   <= hold_red_reg;
                pal_green[addr_reg] <= hold_green_reg;
                pal_blue[addr_reg]  <= color_in;
            end else begin
                ovl_red[addr_reg[3:0]]   <= hold_red_reg;
                ovl_green[addr_reg[3:0]] <= hold_green_reg;
                ovl_blue[addr_reg[3:0]]  <= color_in;
            end
        end
    end

    // read mux; narrow colors return zeros above bit 5
    always @* begin
        rd_color = 8'h00;
        rd_value = 8'h00;
        if (host_rs == `PDP_RS_PAL_DATA) begin
            rd_color = (step_reg == 2'h0) ? pal_red[addr_reg] :
                       (step_reg == 2'h1) ? pal_green[addr_reg] : pal_blue[addr_reg];
        end else begin
            rd_color = (step_reg == 2'h0) ? ovl_red[addr_reg[3:0]] :
                       (step_reg == 2'h1) ? ovl_green[addr_reg[3:0]] : ovl_blue[addr_reg[3:0]];
        end
        case (host_rs)
            `PDP_RS_MASK:     rd_value = mask_red_reg;
            `PDP_RS_CMD:      rd_value = command_control_reg;
            `PDP_RS_PAL_DATA,
            `PDP_RS_OVL_DATA: rd_value = wide_colors ? rd_color : {2'b00, rd_color[7:2]};
            default:          rd_value = addr_reg;
        endcase
    end

    // ----------------------------------------
    // pixel pipeline: sample, look up, select
    // ----------------------------------------
    // every source walks the same two stages, so mode or overlay
    // changes never shift pixels against sync and blank
    reg  [7:0] s1_red_reg, s1_green_reg, s1_blue_reg;
    reg  [1:0] s1_sel_reg;
    reg  [3:0] s1_ovl_reg;
    reg        s1_sync_reg, s1_blank_reg, s1_valid_reg;
    reg  [7:0] s2_pal_r_reg, s2_pal_g_reg, s2_pal_b_reg;
    reg  [7:0] s2_byp_r_reg, s2_byp_g_reg, s2_byp_b_reg;
    reg  [7:0] s2_ovl_r_reg, s2_ovl_g_reg, s2_ovl_b_reg;
    reg  [1:0] s2_kind_reg, kind;
    reg        s2_sync_reg, s2_blank_reg, s2_valid_reg;
    reg  [7:0] idx_r, idx_g, idx_b, byp_r, byp_g, byp_b;
    reg  [7:0] raw_pix, msk_pix, out_r, out_g, out_b;
    wire [1:0] cmode;
    wire       advance, fifo_out_valid;
    wire [25:0] fifo_in, fifo_out;

    assign cmode     = command_control_reg[`PDP_CMD_MODE_HI:`PDP_CMD_MODE_LO];
    assign pix_ready = advance;

    // index and bypass decode from the sampled inputs
    always @* begin
        {idx_r, idx_g, idx_b, byp_r, byp_g, byp_b} = 48'h000000000000;
        kind  = `PDP_KIND_ZERO;
        raw_pix = (cmode == `PDP_CM_RED)   ? s1_red_reg :
                  (cmode == `PDP_CM_GREEN) ? s1_green_reg : s1_blue_reg;
        msk_pix = raw_pix & ((cmode == `PDP_CM_RED)   ? mask_red_reg :
                             (cmode == `PDP_CM_GREEN) ? mask_green_reg : mask_blue_reg);
        if (s1_ovl_reg != 4'h0) begin
            kind = `PDP_KIND_OVL;
        end else begin
            case (s1_sel_reg)
                `PDP_SEL_TRUE: begin
                    idx_r = s1_red_reg & mask_red_reg;
                    idx_g = s1_green_reg & mask_green_reg;
                    idx_b = s1_blue_reg & mask_blue_reg;
                    kind  = (cmode == `PDP_CM_15BIT) ? `PDP_KIND_ZERO : `PDP_KIND_PAL;
                end
                `PDP_SEL_TRUE_BYP: begin
                    {byp_r, byp_g, byp_b} = {s1_red_reg, s1_green_reg, s1_blue_reg};
                    kind  = (cmode == `PDP_CM_15BIT) ? `PDP_KIND_ZERO : `PDP_KIND_BYP;
                end
                `PDP_SEL_PSEUDO: begin
                    kind = `PDP_KIND_PAL;
                    if (cmode == `PDP_CM_15BIT) begin
                        // 15-bit palette, upper index bits forced low
                        idx_r = {3'b000, s1_red_reg[6:2]} & mask_red_reg;
                        idx_g = {3'b000, s1_red_reg[1:0], s1_green_reg[7:5]} & mask_green_reg;
                        idx_b = {3'b000, s1_green_reg[4:0]} & mask_blue_reg;
                    end else begin
                        idx_r = msk_pix;
                        idx_g = msk_pix;
                        idx_b = msk_pix;
                    end
                end
                default: begin
                    kind = `PDP_KIND_BYP;
                    if (cmode == `PDP_CM_15BIT) begin
                        byp_r = {s1_red_reg[6:2], 3'b000};
                        byp_g = {s1_red_reg[1:0], s1_green_reg[7:5], 3'b000};
                        byp_b = {s1_green_reg[4:0], 3'b000};
                    end else begin
                        byp_r = {raw_pix[7:5], 5'h00};
                        byp_g = {raw_pix[4:2], 5'h00};
                        byp_b = {raw_pix[1:0], 6'h00};
                    end
                end
            endcase
        end
    end

    // whole pipe stalls together when the fifo is full
    always @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            {s1_valid_reg, s2_valid_reg, s1_sync_reg, s1_blank_reg, s2_sync_reg, s2_blank_reg} <= 6'h00;
            {s1_red_reg, s1_green_reg, s1_blue_reg, s1_sel_reg, s1_ovl_reg} <= 30'h00000000;
            s2_kind_reg  <= `PDP_KIND_ZERO;
        end else if (advance) begin
            s1_valid_reg <= pix_valid;
            s1_red_reg   <= red_pixel_in;
            s1_green_reg <= green_pixel_in;
            s1_blue_reg  <= blue_pixel_in;
            s1_sel_reg   <= mode_select_pins;
            s1_ovl_reg   <= overlay_select;
            s1_sync_reg  <= sync_n;
            s1_blank_reg <= blank_n;
            s2_valid_reg <= s1_valid_reg;
            s2_kind_reg  <= kind;
            s2_sync_reg  <= s1_sync_reg;
            s2_blank_reg <= s1_blank_reg;
        end
    end

    // table reads registered in the same stage for all sources
    always @(posedge clk) begin
        if (advance) begin
            s2_pal_r_reg <= pal_red[idx_r];
            s2_pal_g_reg <= pal_green[idx_g];
            s2_pal_b_reg <= pal_blue[idx_b];
            s2_byp_r_reg <= byp_r;
            s2_byp_g_reg <= byp_g;
            s2_byp_b_reg <= byp_b;
            s2_ovl_r_reg <= ovl_red[s1_ovl_reg];
            s2_ovl_g_reg <= ovl_green[s1_ovl_reg];
            s2_ovl_b_reg <= ovl_blue[s1_ovl_reg];
        end
    end

    // source select; blank discards pixel and overlay alike
    always @* begin
        {out_r, out_g, out_b} = 24'h000000;
        if (s2_blank_reg) begin
            case (s2_kind_reg)
                `PDP_KIND_PAL: {out_r, out_g, out_b} = {s2_pal_r_reg, s2_pal_g_reg, s2_pal_b_reg};
                `PDP_KIND_BYP: {out_r, out_g, out_b} = {s2_byp_r_reg, s2_byp_g_reg, s2_byp_b_reg};
                `PDP_KIND_OVL: {out_r, out_g, out_b} = {s2_ovl_r_reg, s2_ovl_g_reg, s2_ovl_b_reg};
                default:       out_r = 8'h00;
            endcase
        end
    end

    assign fifo_in = {s2_sync_reg, s2_blank_reg, out_r, out_g, out_b};

    // ----------------------------------------
    // output buffer and converter stage
    // ----------------------------------------
    pdp_fifo #(
        .WIDTH  (26),
        .DEPTH  (FIFO_DEPTH),
        .ADDR_W (FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n_reg),
        .in_valid  (s2_valid_reg),
        .in_ready  (advance),
        .in_data   (fifo_in),
        .out_valid (fifo_out_valid),
        .out_ready (video_ready),
        .out_data  (fifo_out)
    );

    reg [7:0] vid_r_reg, vid_g_reg, vid_b_reg;
    reg       vid_sync_reg, vid_ped_reg, vid_valid_reg;

    // current components: sync source off on sync low, pedestal
    // only outside blanking; both low gives zero output
    always @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            {vid_valid_reg, vid_sync_reg, vid_ped_reg} <= 3'h0;
            {vid_r_reg, vid_g_reg, vid_b_reg} <= 24'h000000;
        end else if (video_ready) begin
            vid_valid_reg <= fifo_out_valid;
            vid_r_reg     <= fifo_out[23:16];
            vid_g_reg     <= fifo_out[15:8];
            vid_b_reg     <= fifo_out[7:0];
            vid_sync_reg  <= fifo_out[25];
            vid_ped_reg   <= fifo_out[24] & command_control_reg[`PDP_CMD_PEDESTAL];
        end
    end

    assign video_valid          = vid_valid_reg;
    assign analog_color_red     = vid_r_reg;
    assign analog_color_green   = vid_g_reg;
    assign analog_color_blue    = vid_b_reg;
    assign video_sync_source_on = vid_sync_reg;
    assign video_pedestal_on    = vid_ped_reg;
endmodule
`default_nettype wire
